/* common/sg_map.svh */
// Purpose: Register indexes, field positions and counts for the sound block
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef SG_MAP_SVH
`define SG_MAP_SVH
// Register indexes
`define SG_IDX_OUTCTL 6'h0F
`define SG_IDX_DIVLO 6'h12
`define SG_IDX_DIVHI 6'h13
`define SG_IDX_SAMPLE 6'h14
`define SG_IDX_CTRL 6'h16
`define SG_IDX_LEVEL 6'h17
// Field positions
`define SG_OC_TRUE 1
`define SG_OC_INV 0
`define SG_CT_DAC 0
`define SG_CT_INH 1
`define SG_CT_EN 2
`define SG_CT_NOISE 3
`define SG_CT_MD_LO 2
`define SG_CT_MD_HI 3
`define SG_CT_SEL_LO 4
`define SG_CT_SEL_HI 6
`define SG_LV_LO 6
`define SG_LV_HI 7
// Reset values
`define SG_RST_BYTE 8'h00
`define SG_RST_WORD 32'h0000_0000
`define SG_LFSR_SEED 15'h0001
// Sound clock select codes
`define SG_SEL_DIV2 3'h0
`define SG_SEL_DIV1 3'h4
`define SG_SEL_DIV16 3'h3
`define SG_SEL_OSC 3'h7
`define SG_SEL_LO4 2'h1
// Volume codes
`define SG_VOL_OFF 2'h0
`define SG_VOL_QTR 2'h1
`define SG_VOL_HALF 2'h2
// Terminal counts
`define SG_TONE_TOP 12'hFFF
`define SG_NOISE_TOP 6'h3F
`define SG_POST_TOP 5'h1F
`define SG_SEG_TOP 7'h7F
`endif

/* common/sg_pkg.sv */
// Purpose: Types shared by the sound block and its bench
// Assumes: APB with 32-bit data, byte address in paddr
// Notes:   Constants live in sg_map.svh
`default_nettype none
package sg_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sg_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sg_apb_rsp_t;
   typedef struct packed {
      logic pb1Out;
      logic pb1Oe;
      logic pb0Out;
      logic pb0Oe;
   } sg_pins_t;
   typedef enum logic [1:0] {
      SG_MD_SINGLE = 2'h0,
      SG_MD_TWOEND = 2'h1,
      SG_MD_RSVD = 2'h2,
      SG_MD_PUSH = 2'h3
   } sg_dacmode_t;
endpackage
`default_nettype wire

/* src/sg_sound.sv */
// Purpose: Tone, noise and PWM DAC sound generator behind APB
// Assumes: clk_sys is the system clock; port logic drives direction/data
// Notes:   Summary of operation below
//
// Summary of operation
// R1: Select field picks sound clock divider
// R2: Volume field: off, quarter, half, maximum
// R3: Software keeps sound clock fast per volume
// R4: True enable puts sound on pin1
// R5: Inverse enable puts inverted sound on pin0
// R6: Tone = clock/(1000H-divider)/2
// R7: Function bit picks DAC or tone/noise
// R8: Generator enable starts, stops tone/noise
// R9: Noise select picks noise over tone
// R10: Noise clock = clock/(40H-low six bits)
// R11: DAC requests new sample each period
// R12: Inhibit bit silences DAC pins
// R13: Mode field picks single, two-ended, push-pull
// R14: Software uses undivided clock for DAC
// R15: Sample rate = clock/128/(20H-upper bits)
// R16: Software sets bit 6 zero, 5-0 ones
// R17: Single-pin duty tracks seven-bit sample
// R18: Two-ended: pin1 high or pin0 low
// R19: Push-pull: pin1 or pin0 high pulses
// R20: Sample is two's complement
// R21: Tone toggles at terminal count, reloads
// R22: Noise is a pseudo-random shift sequence
`timescale 1ns/1ps
`default_nettype none
`include "sg_map.svh"
module sg_sound (
   input wire logic clk_sys,
   input wire logic reset,
   input wire sg_pkg::sg_apb_req_t apbReq,
   output sg_pkg::sg_apb_rsp_t apbRsp,
   input wire logic oscClk,
   input wire logic pb1Dir,
   input wire logic pb1Data,
   input wire logic pb0Dir,
   input wire logic pb0Data,
   output sg_pkg::sg_pins_t pins,
   output logic dacReload
);
   import sg_pkg::*;

   //==========================================================
   // Register file and APB slave
   //==========================================================
   logic [1:0] outCtl_ff, nxt_outCtl;
   logic [7:0] divLo_ff, nxt_divLo;
   logic [3:0] divHi_ff, nxt_divHi;
   logic [7:0] sample_ff, nxt_sample;
   logic [6:0] ctrl_ff, nxt_ctrl;
   logic [1:0] level_ff, nxt_level;
   sg_apb_rsp_t rsp_ff, nxt_rsp;
   logic [5:0] idx;
   logic accFirst, accDone;

   // Read view of one register; unmapped reads zero
   function automatic logic [32:0] rdFor(input logic [5:0] i,
         input logic [1:0] oc, input logic [7:0] lo,
         input logic [3:0] hi, input logic [7:0] smp,
         input logic [6:0] ct, input logic [1:0] lv);
      logic [32:0] r;
      r = {1'b0, `SG_RST_WORD};
      unique case (i)
         `SG_IDX_OUTCTL: r[1:0] = oc;
         `SG_IDX_DIVLO: r[7:0] = lo;
         `SG_IDX_DIVHI: r[3:0] = hi;
         `SG_IDX_SAMPLE: r[7:0] = smp;
         `SG_IDX_CTRL: r[6:0] = ct;
         `SG_IDX_LEVEL: r[`SG_LV_HI:`SG_LV_LO] = lv;
         default: r[32] = 1'b1;
      endcase
      return r;
   endfunction

   assign idx = apbReq.paddr[7:2];
   // One wait state: answer prepared, write lands when pready seen
   assign accFirst = apbReq.psel & apbReq.penable & ~rsp_ff.pready;
   assign accDone = apbReq.psel & apbReq.penable & rsp_ff.pready;

   // Next register values
   always_comb begin
      logic [32:0] rd;
      rd = rdFor(idx, outCtl_ff, divLo_ff, divHi_ff, sample_ff,
         ctrl_ff, level_ff);
      nxt_outCtl = outCtl_ff;
      nxt_divLo = divLo_ff;
      nxt_divHi = divHi_ff;
      nxt_sample = sample_ff;
      nxt_ctrl = ctrl_ff;
      nxt_level = level_ff;
      nxt_rsp = rsp_ff;
      nxt_rsp.pready = accFirst;
      if (accFirst) begin
         nxt_rsp.prdata = apbReq.pwrite ? `SG_RST_WORD : rd[31:0];
         nxt_rsp.pslverr = rd[32];
      end
      if (accDone && apbReq.pwrite) begin
         unique case (idx)
            `SG_IDX_OUTCTL: nxt_outCtl = apbReq.pwdata[1:0];
            `SG_IDX_DIVLO: nxt_divLo = apbReq.pwdata[7:0];
            `SG_IDX_DIVHI: nxt_divHi = apbReq.pwdata[3:0];
            `SG_IDX_SAMPLE: nxt_sample = apbReq.pwdata[7:0];
            `SG_IDX_CTRL: nxt_ctrl = apbReq.pwdata[6:0];
            `SG_IDX_LEVEL:
               nxt_level = apbReq.pwdata[`SG_LV_HI:`SG_LV_LO];
            default: nxt_ctrl = ctrl_ff; // Unmapped: no effect
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         outCtl_ff <= 2'(`SG_RST_BYTE);
         divLo_ff <= `SG_RST_BYTE;
         divHi_ff <= 4'(`SG_RST_BYTE);
         sample_ff <= `SG_RST_BYTE;
         ctrl_ff <= 7'(`SG_RST_BYTE);
         level_ff <= 2'(`SG_RST_BYTE);
         rsp_ff <= '0;
      end else begin
         outCtl_ff <= nxt_outCtl;
         divLo_ff <= nxt_divLo;
         divHi_ff <= nxt_divHi;
         sample_ff <= nxt_sample;
         ctrl_ff <= nxt_ctrl;
         level_ff <= nxt_level;
         rsp_ff <= nxt_rsp;
      end
   end
   assign apbRsp = rsp_ff;

   // Decoded control fields
   logic [11:0] divVal;
   logic [2:0] clkSel;
   logic dacFunc, genEn, noiseSel, inhibit, trueEn, invEn;
   sg_dacmode_t dacMode;
   assign divVal = {divHi_ff, divLo_ff};
   assign clkSel = ctrl_ff[`SG_CT_SEL_HI:`SG_CT_SEL_LO];
   assign dacFunc = ctrl_ff[`SG_CT_DAC]; // [R7]
   assign genEn = ctrl_ff[`SG_CT_EN];
   assign noiseSel = ctrl_ff[`SG_CT_NOISE];
   assign inhibit = ctrl_ff[`SG_CT_INH];
   assign dacMode = sg_dacmode_t'(ctrl_ff[`SG_CT_MD_HI:`SG_CT_MD_LO]);
   assign trueEn = outCtl_ff[`SG_OC_TRUE];
   assign invEn = outCtl_ff[`SG_OC_INV];

   //==========================================================
   // Sound clock: prescaler and oscillator edge
   //==========================================================
   logic oscMeta_ff, oscSync_ff, oscDly_ff;
   logic [3:0] preCnt_ff, nxt_preCnt;
   logic [1:0] volPh_ff, nxt_volPh;
   logic sndTick;

   // Tick rate for a select code
   function automatic logic tickFor(input logic [2:0] s,
         input logic [3:0] c, input logic oe);
      if (s == `SG_SEL_DIV1)
         return 1'b1;
      else if (s == `SG_SEL_OSC)
         return oe;
      else if (s == `SG_SEL_DIV2)
         return c[0];
      else if (s == `SG_SEL_DIV16)
         return &c;
      else if (s[1:0] == `SG_SEL_LO4)
         return &c[1:0];
      else
         return &c[2:0];
   endfunction

   assign sndTick = tickFor(clkSel, preCnt_ff,
      oscSync_ff & ~oscDly_ff); // [R1]
   always_comb begin
      nxt_preCnt = preCnt_ff + 4'h1;
      nxt_volPh = sndTick ? volPh_ff + 2'h1 : volPh_ff;
   end

   // Oscillator pin crosses in through two flops, then edge-detected
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         oscMeta_ff <= 1'b0;
         oscSync_ff <= 1'b0;
         oscDly_ff <= 1'b0;
         preCnt_ff <= 4'h0;
         volPh_ff <= 2'h0;
      end else begin
         oscMeta_ff <= oscClk;
         oscSync_ff <= oscMeta_ff;
         oscDly_ff <= oscSync_ff;
         preCnt_ff <= nxt_preCnt;
         volPh_ff <= nxt_volPh;
      end
   end

   //==========================================================
   // Tone and noise generators
   //==========================================================
   logic [11:0] toneCnt_ff, nxt_toneCnt;
   logic toneSq_ff, nxt_toneSq;
   logic [5:0] nCnt_ff, nxt_nCnt;
   logic [14:0] lfsr_ff, nxt_lfsr;
   logic toneOn, noiseOn;
   assign toneOn = genEn & ~dacFunc & ~noiseSel; // [R8] [R9]
   assign noiseOn = genEn & ~dacFunc & noiseSel; // [R8] [R9]

   // Counters run up to terminal count, then reload the divider
   always_comb begin
      nxt_toneCnt = toneCnt_ff;
      nxt_toneSq = toneSq_ff;
      nxt_nCnt = nCnt_ff;
      nxt_lfsr = lfsr_ff;
      if (!toneOn) begin
         nxt_toneCnt = divVal;
         nxt_toneSq = 1'b0;
      end else if (sndTick) begin
         if (toneCnt_ff == `SG_TONE_TOP) begin
            nxt_toneCnt = divVal; // [R6] [R21]
            nxt_toneSq = ~toneSq_ff; // [R21]
         end else begin
            nxt_toneCnt = toneCnt_ff + 12'h001;
         end
      end
      // LFSR keeps its state while off so it never locks at zero
      if (!noiseOn) begin
         nxt_nCnt = divVal[5:0];
      end else if (sndTick) begin
         if (nCnt_ff == `SG_NOISE_TOP) begin
            nxt_nCnt = divVal[5:0]; // [R10]
            nxt_lfsr = {lfsr_ff[13:0], lfsr_ff[14] ^ lfsr_ff[13]}; // [R22]
         end else begin
            nxt_nCnt = nCnt_ff + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         toneCnt_ff <= 12'h000;
         toneSq_ff <= 1'b0;
         nCnt_ff <= 6'h00;
         lfsr_ff <= `SG_LFSR_SEED;
      end else begin
         toneCnt_ff <= nxt_toneCnt;
         toneSq_ff <= nxt_toneSq;
         nCnt_ff <= nxt_nCnt;
         lfsr_ff <= nxt_lfsr;
      end
   end

   // Volume chops the signal at the sound clock, hence the clock floor
   logic volGate, sndSig;
   always_comb begin
      unique case (level_ff)
         `SG_VOL_OFF: volGate = 1'b0; // [R2]
         `SG_VOL_QTR: volGate = volPh_ff == 2'h0; // [R2]
         `SG_VOL_HALF: volGate = ~volPh_ff[0]; // [R2]
         default: volGate = 1'b1; // [R2]
      endcase
      sndSig = (noiseOn ? lfsr_ff[0] : toneSq_ff) & volGate;
   end

   //==========================================================
   // PWM DAC: sample rate and segment counters
   //==========================================================
   logic [4:0] post_ff, nxt_post;
   logic [6:0] seg_ff, nxt_seg;
   logic [7:0] smp_ff, nxt_smp;
   logic req_ff, nxt_req;

   // Post-scaler first, then 128 segments per sample period
   always_comb begin
      nxt_post = post_ff;
      nxt_seg = seg_ff;
      nxt_smp = smp_ff;
      nxt_req = 1'b0;
      if (!dacFunc) begin
         nxt_post = divVal[11:7];
         nxt_seg = 7'h00;
      end else if (sndTick) begin
         if (post_ff == `SG_POST_TOP) begin
            nxt_post = divVal[11:7]; // [R15]
            nxt_seg = seg_ff + 7'h01;
            if (seg_ff == `SG_SEG_TOP) begin
               nxt_smp = sample_ff;
               nxt_req = 1'b1; // [R11]
            end
         end else begin
            nxt_post = post_ff + 5'h01;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         post_ff <= 5'h00;
         seg_ff <= 7'h00;
         smp_ff <= `SG_RST_BYTE;
         req_ff <= 1'b0;
      end else begin
         post_ff <= nxt_post;
         seg_ff <= nxt_seg;
         smp_ff <= nxt_smp;
         req_ff <= nxt_req;
      end
   end
   assign dacReload = req_ff;

   // Pulse shapes per mode; sample is two's complement
   logic [7:0] mag;
   logic segLt, dacB1, dacB0;
   always_comb begin
      mag = smp_ff[7] ? 8'h00 - smp_ff : smp_ff; // [R20]
      segLt = {1'b0, seg_ff} < mag;
      dacB1 = 1'b0;
      dacB0 = 1'b0;
      unique case (dacMode)
         SG_MD_SINGLE: begin
            dacB1 = seg_ff < {~smp_ff[6], smp_ff[5:0]}; // [R17]
            dacB0 = ~dacB1; // [R17]
         end
         SG_MD_TWOEND: begin
            dacB1 = ~smp_ff[7] & segLt; // [R18]
            dacB0 = ~(smp_ff[7] & segLt); // [R18]
         end
         SG_MD_PUSH: begin
            dacB1 = ~smp_ff[7] & segLt; // [R19]
            dacB0 = smp_ff[7] & segLt; // [R19]
         end
         SG_MD_RSVD: dacB1 = 1'b0; // [R13]
      endcase
      if (inhibit) begin
         dacB1 = 1'b0; // [R12]
         dacB0 = 1'b0; // [R12]
      end
   end

   //==========================================================
   // Port B pin mux
   //==========================================================
   sg_pins_t pins_ff, nxt_pins;
   always_comb begin
      nxt_pins.pb1Oe = pb1Dir;
      nxt_pins.pb0Oe = pb0Dir;
      nxt_pins.pb1Out = pb1Data;
      nxt_pins.pb0Out = pb0Data;
      if (trueEn && pb1Dir)
         nxt_pins.pb1Out = dacFunc ? dacB1 : sndSig; // [R4]
      if (invEn && pb0Dir)
         nxt_pins.pb0Out = dacFunc ? dacB0 : ~sndSig; // [R5]
   end

   always_ff @(posedge clk_sys) begin
      if (reset)
         pins_ff <= '0;
      else
         pins_ff <= nxt_pins;
   end
   assign pins = pins_ff;

   //==========================================================
   // Checks
   //==========================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   property p_fullRate;
      (clkSel == `SG_SEL_DIV1) |-> sndTick;
   endproperty
   a_fullRate: assert property (p_fullRate) // [R1]
      else $error("undivided select missed a tick");

   // Only judged while the select stays put; a select change may tick at once
   property p_halfRate;
      (clkSel == `SG_SEL_DIV2 && $past(clkSel) == `SG_SEL_DIV2
         && $past(sndTick)) |-> !sndTick;
   endproperty
   a_halfRate: assert property (p_halfRate) // [R1]
      else $error("half rate ticked twice");

   property p_silent;
      (level_ff == `SG_VOL_OFF && !dacFunc && trueEn && pb1Dir)
         |=> !pins_ff.pb1Out;
   endproperty
   a_silent: assert property (p_silent) // [R2]
      else $error("sound while volume off");

   property p_gpio1;
      !trueEn |=> pins_ff.pb1Out == $past(pb1Data);
   endproperty
   a_gpio1: assert property (p_gpio1) // [R4]
      else $error("pin1 not plain port");

   property p_inv0;
      (invEn && pb0Dir && !dacFunc) |=> pins_ff.pb0Out == !$past(sndSig);
   endproperty
   a_inv0: assert property (p_inv0) // [R5]
      else $error("pin0 not inverse sound");

   property p_toneWrap;
      (toneOn && sndTick && toneCnt_ff == `SG_TONE_TOP)
         |=> toneCnt_ff == $past(divVal) && toneSq_ff != $past(toneSq_ff);
   endproperty
   a_toneWrap: assert property (p_toneWrap) // [R21]
      else $error("tone did not reload and toggle");

   property p_genOff;
      !toneOn |=> !toneSq_ff;
   endproperty
   a_genOff: assert property (p_genOff) // [R8]
      else $error("tone runs while stopped");

   property p_noiseStep;
      (noiseOn && sndTick && nCnt_ff == `SG_NOISE_TOP)
         |=> lfsr_ff != $past(lfsr_ff) && nCnt_ff == $past(divVal[5:0]);
   endproperty
   a_noiseStep: assert property (p_noiseStep) // [R10]
      else $error("noise clock did not step");

   property p_reqPulse;
      req_ff |-> $past(dacFunc) ##1 !req_ff;
   endproperty
   a_reqPulse: assert property (p_reqPulse) // [R11]
      else $error("reload request not a single pulse");

   property p_inhibit;
      (dacFunc && inhibit && trueEn && pb1Dir) |=> !pins_ff.pb1Out;
   endproperty
   a_inhibit: assert property (p_inhibit) // [R12]
      else $error("DAC pin not inhibited");

   property p_pushZero;
      (dacFunc && !inhibit && dacMode == SG_MD_PUSH && smp_ff == 8'h00
         && trueEn && pb1Dir && invEn && pb0Dir)
         |=> !pins_ff.pb1Out && !pins_ff.pb0Out;
   endproperty
   a_pushZero: assert property (p_pushZero) // [R19]
      else $error("push-pull zero not both low");
endmodule
`default_nettype wire

/* dv/sg_amp_model.sv */
// Purpose: Speaker or buzzer load on the two sound pins
// Assumes: No pull on either pin; an undriven pin floats
// Notes:   Tallies levels and edges for the bench to judge
`timescale 1ns/1ps
`default_nettype none
module sg_amp_model (
   input wire logic clk_sys,
   input wire logic clear,
   input wire sg_pkg::sg_pins_t pins,
   output logic [15:0] hi1_ff,
   output logic [15:0] hi0_ff,
   output logic [15:0] edges1_ff,
   output logic [15:0] same_ff
);
   import sg_pkg::*;
   logic lvl1;
   logic lvl0;
   logic last1_ff;
   logic last0_ff;
   // ======
   // Pin levels
   // Floating pin shows the opposite of its last level, never a stale one
   assign lvl1 = pins.pb1Oe ? pins.pb1Out : ~last1_ff;
   assign lvl0 = pins.pb0Oe ? pins.pb0Out : ~last0_ff;
   // Tallies, cleared by the bench between windows
   always_ff @(posedge clk_sys) begin
      last1_ff <= clear ? 1'b0 : lvl1;
      last0_ff <= clear ? 1'b0 : lvl0;
      if (clear) begin
         hi1_ff <= 16'h0000;
         hi0_ff <= 16'h0000;
         edges1_ff <= 16'h0000;
         same_ff <= 16'h0000;
      end else begin
         hi1_ff <= hi1_ff + 16'(lvl1);
         hi0_ff <= hi0_ff + 16'(lvl0);
         edges1_ff <= edges1_ff + 16'(lvl1 != last1_ff);
         same_ff <= same_ff + 16'(lvl1 == lvl0);
      end
   end
endmodule
`default_nettype wire

/* dv/sg_sound_tb.sv */
// Purpose: Self-checking bench for the sound block
// Assumes: One APB transfer at a time; pins loaded by the speaker model
// Notes:   Oscillator stand-in runs far faster than a crystal, short runs
`timescale 1ns/1ps
`default_nettype none
`include "sg_map.svh"
module sg_sound_tb;
   import sg_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic oscClk = 1'b0;
   logic pb1Dir = 1'b1;
   logic pb1Data = 1'b0;
   logic pb0Dir = 1'b1;
   logic pb0Data = 1'b0;
   logic clear = 1'b1;
   sg_apb_req_t apbReq = '0;
   sg_apb_rsp_t apbRsp;
   sg_pins_t pins;
   logic dacReload;
   logic [15:0] hi1;
   logic [15:0] hi0;
   logic [15:0] edges1;
   logic [15:0] same;
   logic [31:0] seed = 32'h4784_140e;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [5:0] idxs [6] = '{`SG_IDX_OUTCTL, `SG_IDX_DIVLO, `SG_IDX_DIVHI,
      `SG_IDX_SAMPLE, `SG_IDX_CTRL, `SG_IDX_LEVEL};
   logic [7:0] masks [6] = '{8'h03, 8'hFF, 8'h0F, 8'hFF, 8'h7F, 8'hC0};
   logic [2:0] sels [8] = '{3'h4, 3'h0, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
   int divs [8] = '{1, 2, 4, 4, 8, 8, 16, 40};
   // Mode, sample, pin1 high count, pin0 high count per 128 segments
   logic [31:0] rows [9] = '{32'h0000_4040, 32'h0020_6020, 32'h00C0_0080,
      32'h0105_0580, 32'h01F6_0076, 32'h037F_7F00, 32'h0381_007F,
      32'h0300_0000, 32'h0210_0000};

   sg_sound i_sg_sound (.clk_sys(clk_sys), .reset(reset), .apbReq(apbReq),
      .apbRsp(apbRsp), .oscClk(oscClk), .pb1Dir(pb1Dir), .pb1Data(pb1Data),
      .pb0Dir(pb0Dir), .pb0Data(pb0Data), .pins(pins),
      .dacReload(dacReload));
   sg_amp_model i_sg_amp_model (.clk_sys(clk_sys), .clear(clear),
      .pins(pins), .hi1_ff(hi1), .hi0_ff(hi0), .edges1_ff(edges1),
      .same_ff(same));

   // ======
   // Clocks and hang guard
   always #2.5 clk_sys = ~clk_sys;
   // Oscillator stand-in: one tick every 40 system cycles
   always begin
      repeat (20) @(posedge clk_sys);
      oscClk <= ~oscClk;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         n_errors = n_errors + 1;
         final_report();
      end
   end

   // ======
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction
   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // Setup, access, then hold until pready is seen at an edge
   task automatic apb(input logic wr, input logic [5:0] idx,
         input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      apbReq.psel <= 1'b1;
      apbReq.pwrite <= wr;
      apbReq.paddr <= {idx, 2'b00};
      apbReq.pwdata <= wd;
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 20);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      if (n >= 20) check("pready", 32'h1, 32'h0);
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   task automatic set_div(input logic [11:0] dv);
      apb(1'b1, `SG_IDX_DIVLO, {24'h0, dv[7:0]});
      apb(1'b1, `SG_IDX_DIVHI, {28'h0, dv[11:8]});
   endtask
   // Fresh tally over n edges, read once the last edge has landed
   task automatic window(input int n);
      @(posedge clk_sys);
      clear <= 1'b1;
      @(posedge clk_sys);
      clear <= 1'b0;
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_reload(output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (dacReload !== 1'b1 && n < 600);
   endtask
   task automatic final_report();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ======
   // Main sequence
   initial begin
      logic [11:0] dv;
      int n;
      int m;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      // Reset values, random readback, refused slot
      foreach (idxs[i]) begin
         apb(1'b0, idxs[i], 32'h0);
         check("reset value", 32'h0, rd);
      end
      foreach (idxs[i]) begin
         seed = xs(seed);
         apb(1'b1, idxs[i], seed);
         apb(1'b0, idxs[i], 32'h0);
         check("readback", {24'h0, seed[7:0] & masks[i]}, rd);
      end
      apb(1'b0, 6'h10, 32'h0);
      check("pslverr", 32'h1, {31'h0, err});
      check("unmapped data", 32'h0, rd);
      // Tone at every clock select with a random short divider
      apb(1'b1, `SG_IDX_OUTCTL, 32'h3);
      apb(1'b1, `SG_IDX_LEVEL, 32'hC0);
      foreach (sels[i]) begin
         seed = xs(seed);
         dv = {8'hFF, seed[3:1], 1'b0};
         m = divs[i] * (4096 - int'(dv));
         set_div(dv);
         // Stop first so the count restarts from the new divider
         apb(1'b1, `SG_IDX_CTRL, {25'h0, sels[i], 4'h0});
         apb(1'b1, `SG_IDX_CTRL, {25'h0, sels[i], 4'h4});
         window(32 * m);
         check("tone edges", 1, (edges1 >= 31 && edges1 <= 33));
         check("pin0 inverse", 0, same);
      end
      apb(1'b1, `SG_IDX_CTRL, 32'h40);
      window(200);
      check("stopped edges", 0, edges1);
      // Volume off and quarter; odd half period so the gate meets the tone
      set_div(12'hFFD);
      apb(1'b1, `SG_IDX_CTRL, 32'h44);
      apb(1'b1, `SG_IDX_LEVEL, 32'h00);
      window(64);
      check("silent pin1", 0, hi1);
      apb(1'b1, `SG_IDX_LEVEL, 32'h40);
      window(256);
      check("quarter level", 1, (hi1 > 0 && hi1 < 64));
      apb(1'b1, `SG_IDX_LEVEL, 32'hC0);
      // Noise clock every third tick bounds the edge rate
      apb(1'b1, `SG_IDX_CTRL, 32'h4C);
      window(256);
      check("noise edges", 1, (edges1 > 0 && edges1 <= 128));
      check("noise inverse", 0, same);
      // Pins fall back to port data and direction
      apb(1'b1, `SG_IDX_OUTCTL, 32'h0);
      repeat (4) begin
         seed = xs(seed);
         @(posedge clk_sys);
         pb1Data <= seed[0];
         pb0Data <= seed[1];
         repeat (3) @(posedge clk_sys);
         #1;
         check("pin1 port data", pb1Data, pins.pb1Out);
         check("pin0 port data", pb0Data, pins.pb0Out);
      end
      @(posedge clk_sys);
      pb1Dir <= 1'b0;
      pb0Dir <= 1'b0;
      pb1Data <= 1'b0;
      pb0Data <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("pin enables", 0, {pins.pb1Oe, pins.pb0Oe});
      @(posedge clk_sys);
      pb1Dir <= 1'b1;
      pb0Dir <= 1'b1;
      apb(1'b1, `SG_IDX_OUTCTL, 32'h3);
      // DAC: every pin mode, undivided clock, random sample period
      foreach (rows[i]) begin
         seed = xs(seed);
         m = 1 + int'(seed[0]);
         set_div({5'(32 - m), 1'b0, 6'h3F});
         apb(1'b1, `SG_IDX_SAMPLE, {24'h0, rows[i][23:16]});
         apb(1'b1, `SG_IDX_CTRL, {25'h0, 3'h4, rows[i][25:24], 2'h1});
         wait_reload(n);
         wait_reload(n);
         check("reload spacing", 128 * m, n);
         window(128 * m);
         check("dac pin1 high", m * rows[i][15:8], hi1);
         check("dac pin0 high", m * rows[i][7:0], hi0);
      end
      apb(1'b1, `SG_IDX_SAMPLE, 32'h7F);
      apb(1'b1, `SG_IDX_CTRL, 32'h4F);
      window(256);
      check("inhibited pins", 0, {hi1, hi0});
      final_report();
   end
endmodule
`default_nettype wire
